// *** rtl/parmu_pkg.sv ***
// Operation
// - Two banks of eight base/descriptor pairs: kernel bank and user bank.
// - Bank chosen by current mode, or previous mode when the access asks.
// - Mode 00 selects kernel, 11 user; 01 and 10 abort every reference.
// - Page register writes are accepted in any processor mode.
// - Page registers reachable only through the processor register port.
// - Base register holds 12-bit physical block; bits 15-12 reserved.
// - Key 00 aborts all, 01 aborts writes, 10 aborts all, 11 allows all.
// - An aborted reference is cancelled; memory is never read or written.
// - Stores and read-modify-write references count as writes.
// - Descriptor bit 3 picks growth: 0 upward, 1 downward.
// - Descriptor bit 6 set by page writes, cleared by register writes.
// - Descriptor bits 14-8 hold 7-bit length limit; bit 15 unused.
// - Upward page: block above limit gives length fault and abort.
// - Downward page length counts down from block 177 octal.
// - Virtual address: top 3 bits pick pair, low 13 bits displacement.
// - Displacement splits into 7-bit block and 6-bit in-block offset.
// - Physical block is virtual block plus page base block.
// - Physical block joined with 6-bit offset gives 18-bit address.
// - Relocation completes within 150 ns of address presentation.
// - Unit supplies every bus address, passed through or relocated.
// - Status bit 0 clear passes addresses through; set relocates and checks.
// - Status bits 15-13 record non-resident, length and read-only aborts.
`default_nettype none
package parmu_pkg;
	// ---------------------------------------------------------------
	// Register port map (word index on the processor register port).
	// ---------------------------------------------------------------
	localparam logic [5:0] ADDR_BASE_KERNEL  = 6'h00;
	localparam logic [5:0] ADDR_DESC_KERNEL  = 6'h08;
	localparam logic [5:0] ADDR_BASE_USER    = 6'h10;
	localparam logic [5:0] ADDR_DESC_USER    = 6'h18;
	localparam logic [5:0] ADDR_STATUS       = 6'h20;
	// ---------------------------------------------------------------
	// Field positions.
	// ---------------------------------------------------------------
	localparam int BASE_BITS       = 12;
	localparam int DESC_KEY_LSB    = 1;
	localparam int DESC_GROW_BIT   = 3;
	localparam int DESC_WRITTEN    = 6;
	localparam int DESC_LIMIT_LSB  = 8;
	localparam int STAT_ENABLE     = 0;
	localparam int STAT_NONRES     = 15;
	localparam int STAT_LENGTH     = 14;
	localparam int STAT_RDONLY     = 13;
	localparam logic [15:0] DESC_WRITE_MASK = 16'h7f0e;
	localparam logic [15:0] BASE_RESET      = 16'h0000;
	localparam logic [15:0] DESC_RESET      = 16'h0000;
	localparam logic [15:0] STAT_RESET      = 16'h0000;
	localparam logic [1:0] MODE_KERNEL = 2'h0;
	localparam logic [1:0] MODE_USER   = 2'h3;
	localparam logic [1:0] KEY_RDONLY  = 2'h1;
	localparam logic [1:0] KEY_RDWR    = 2'h3;
	localparam logic [6:0] BLOCK_TOP   = 7'h7f;
	// ---------------------------------------------------------------
	// Timing: the address path is combinational, one cycle at most.
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS     = 25;
	localparam int RELOC_TIME_NS     = 150;
	localparam int RELOC_CYCLES      = RELOC_TIME_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// *** rtl/parmu_check_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// Carries one page's translation and check between the top and the checker.
interface parmu_check_if;
	logic [15:0] desc;
	logic [6:0]  block;
	logic        is_write;
	logic        nonres;
	logic        length;
	logic        rdonly;
	modport top_side (output desc, output block, output is_write, input nonres, input length, input rdonly);
	modport chk_side (input desc, input block, input is_write, output nonres, output length, output rdonly);
endinterface
`default_nettype wire

// *** rtl/parmu_page_check.sv ***
`timescale 1ns/100ps
`default_nettype none
module parmu_page_check (
	parmu_check_if.chk_side chk
);
	wire [1:0] key;
	wire       grow_down;
	wire [6:0] limit;
	// --------------------------------------------------------------
	// Access key and length decoding.
	// --------------------------------------------------------------
	// Fields of the selected descriptor.
	assign key       = chk.desc[parmu_pkg::DESC_KEY_LSB +: 2];
	assign grow_down = chk.desc[parmu_pkg::DESC_GROW_BIT];
	assign limit     = chk.desc[parmu_pkg::DESC_LIMIT_LSB +: 7];
	// Keys 00 and 10 refuse everything, 01 refuses writes only.
	assign chk.nonres = (key == 2'h0) || (key == 2'h2);
	assign chk.rdonly = (key == parmu_pkg::KEY_RDONLY) && chk.is_write;
	// Upward pages fault above the limit, downward pages below it.
	assign chk.length = grow_down ? (chk.block < limit) : (chk.block > limit);
endmodule // parmu_page_check
`default_nettype wire

// *** rtl/parmu_unit.sv ***
`timescale 1ns/100ps
`default_nettype none
module parmu_unit (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] virt_addr,
	input  wire logic        ref_valid,
	input  wire logic        ref_write,
	input  wire logic        use_prev_mode,
	input  wire logic [1:0]  cur_mode,
	input  wire logic [1:0]  prev_mode,
	input  wire logic        reg_sel,
	input  wire logic        reg_write,
	input  wire logic [5:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	output      logic [15:0] reg_rdata,
	output      logic [17:0] phys_addr,
	output      logic        bus_valid,
	output      logic        ref_abort
);
	logic [15:0] base_reg [2][8];
	logic [15:0] desc_reg [2][8];
	logic [15:0] status_reg;
	logic [15:0] rdata_reg;
	wire  [1:0]  mode;
	wire         mode_bad;
	wire         bank;
	wire  [2:0]  page_select_field;
	wire  [12:0] page_offset;
	wire  [6:0]  virtual_block_index;
	wire  [5:0]  block_offset;
	wire  [11:0] page_base_block;
	wire  [11:0] phys_block;
	wire         enabled;
	wire         any_abort;
	wire         nonres_flag;
	wire         page_written;
	wire         reg_wr;
	wire         reg_bank;
	wire  [2:0]  reg_idx;
	wire         reg_is_base;
	wire         reg_is_desc;
	wire         reg_is_stat;
	parmu_check_if chk_bus ();

	// ----------------------------------------------------------------
	// Mode and bank selection.
	// ----------------------------------------------------------------
	// Pick current or previous mode; only 00 and 11 are legal.
	assign mode     = use_prev_mode ? prev_mode : cur_mode;
	assign mode_bad = (mode != parmu_pkg::MODE_KERNEL) && (mode != parmu_pkg::MODE_USER);
	assign bank     = (mode == parmu_pkg::MODE_USER);

	// ----------------------------------------------------------------
	// Virtual address split and relocation.
	// ----------------------------------------------------------------
	// Top three bits select the pair, the rest is block and offset.
	assign page_select_field   = virt_addr[15:13];
	assign page_offset         = virt_addr[12:0];
	assign virtual_block_index = page_offset[12:6];
	assign block_offset        = page_offset[5:0];
	assign page_base_block     = base_reg[bank][page_select_field][parmu_pkg::BASE_BITS-1:0];
	assign phys_block          = page_base_block + {5'h00, virtual_block_index};

	// Feed the selected page to the checker.
	assign chk_bus.desc     = desc_reg[bank][page_select_field];
	assign chk_bus.block    = virtual_block_index;
	assign chk_bus.is_write = ref_write;

	parmu_page_check u_check (
		.chk (chk_bus.chk_side)
	);

	// ----------------------------------------------------------------
	// Abort and bus outputs; the path is combinational, well inside 150 ns.
	// ----------------------------------------------------------------
	assign enabled      = status_reg[parmu_pkg::STAT_ENABLE];
	assign nonres_flag  = chk_bus.nonres || mode_bad;
	assign any_abort    = enabled && (nonres_flag || chk_bus.length || chk_bus.rdonly);
	assign ref_abort    = ref_valid && any_abort;
	assign bus_valid    = ref_valid && !any_abort;
	// Disabled unit passes the 16-bit address through unchanged.
	assign phys_addr    = enabled ? {phys_block, block_offset} : {2'h0, virt_addr};
	assign page_written = ref_valid && ref_write && enabled && !any_abort;

	// ----------------------------------------------------------------
	// Register port decode; no mode check on writes.
	// ----------------------------------------------------------------
	assign reg_wr      = reg_sel && reg_write;
	assign reg_bank    = reg_addr[4];
	assign reg_idx     = reg_addr[2:0];
	assign reg_is_base = (reg_addr[5] == 1'b0) && (reg_addr[3] == 1'b0);
	assign reg_is_desc = (reg_addr[5] == 1'b0) && (reg_addr[3] == 1'b1);
	assign reg_is_stat = (reg_addr == parmu_pkg::ADDR_STATUS);

	// Page register pairs, one generate slot per bank and page.
	for (genvar b = 0; b < 2; b++) begin : g_bank
		for (genvar p = 0; p < 8; p++) begin : g_page
			wire hit_base;
			wire hit_desc;
			wire hit_page;
			assign hit_base = reg_wr && reg_is_base && (reg_bank == 1'(b)) && (reg_idx == 3'(p));
			assign hit_desc = reg_wr && reg_is_desc && (reg_bank == 1'(b)) && (reg_idx == 3'(p));
			assign hit_page = page_written && (bank == 1'(b)) && (page_select_field == 3'(p));
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					base_reg[b][p] <= parmu_pkg::BASE_RESET;
				end else if (hit_base) begin
					base_reg[b][p] <= {4'h0, reg_wdata[11:0]};
				end
			end
			// Written flag: a page write in the same cycle wins over the clear.
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					desc_reg[b][p] <= parmu_pkg::DESC_RESET;
				end else begin
					if (hit_desc) begin
						desc_reg[b][p] <= reg_wdata & parmu_pkg::DESC_WRITE_MASK;
					end
					if (hit_page) begin
						desc_reg[b][p][parmu_pkg::DESC_WRITTEN] <= 1'b1;
					end else if (hit_base || hit_desc) begin
						desc_reg[b][p][parmu_pkg::DESC_WRITTEN] <= 1'b0;
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Status register: enable bit and sticky abort flags.
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= parmu_pkg::STAT_RESET;
		end else begin
			if (reg_wr && reg_is_stat) begin
				status_reg <= {reg_wdata[15:13], 12'h000, reg_wdata[0]};
			end
			if (ref_abort) begin
				status_reg[parmu_pkg::STAT_NONRES] <= status_reg[parmu_pkg::STAT_NONRES] | nonres_flag;
				status_reg[parmu_pkg::STAT_LENGTH] <= status_reg[parmu_pkg::STAT_LENGTH] | chk_bus.length;
				status_reg[parmu_pkg::STAT_RDONLY] <= status_reg[parmu_pkg::STAT_RDONLY] | chk_bus.rdonly;
			end
		end
	end

	// Registered read data, unmapped addresses read zero.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 16'h0000;
		end else if (reg_sel && !reg_write) begin
			rdata_reg <= reg_is_base ? base_reg[reg_bank][reg_idx] :
			             reg_is_desc ? desc_reg[reg_bank][reg_idx] :
			             reg_is_stat ? status_reg : 16'h0000;
		end
	end
	assign reg_rdata = rdata_reg;
endmodule // parmu_unit
`default_nettype wire

// *** verification/parmu_unit_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Port checks for the relocation unit.
// ------------------------------------------------------------
module parmu_unit_properties (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic [15:0] virt_addr,
	input wire logic        ref_valid,
	input wire logic        use_prev_mode,
	input wire logic [1:0]  cur_mode,
	input wire logic [1:0]  prev_mode,
	input wire logic        reg_sel,
	input wire logic        reg_write,
	input wire logic [5:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic [17:0] phys_addr,
	input wire logic        bus_valid,
	input wire logic        ref_abort
);
	logic       en_reg;
	logic [1:0] mode;
	logic       rd;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Mode in force and the register read strobe.
	assign mode = use_prev_mode ? prev_mode : cur_mode;
	assign rd   = reg_sel & !reg_write;
	// Mirror of the enable bit, taken from status writes.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			en_reg <= 1'b0;
		else if (reg_sel && reg_write && reg_addr == 6'h20)
			en_reg <= reg_wdata[0];
	end
	one_answer_a: assert property ((bus_valid | ref_abort) == ref_valid && !(bus_valid & ref_abort))
		else $error("reference answer inconsistent");
	offset_pass_a: assert property (ref_valid |-> phys_addr[5:0] == virt_addr[5:0])
		else $error("in-block offset altered");
	pass_through_a: assert property (!en_reg && ref_valid |-> bus_valid && phys_addr == {2'h0, virt_addr})
		else $error("disabled address not passed through");
	illegal_mode_a: assert property (en_reg && ref_valid && ^mode |-> ref_abort)
		else $error("illegal mode not aborted");
	abort_enabled_a: assert property (ref_abort |-> en_reg)
		else $error("abort while disabled");
	unmapped_zero_a: assert property (rd && reg_addr > 6'h20 |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	base_reserved_a: assert property (rd && !reg_addr[3] && !reg_addr[5] |=> reg_rdata[15:12] == 4'h0)
		else $error("base reserved bits set");
	written_clear_a: assert property (reg_sel && reg_write && !reg_addr[5] && !ref_valid ##1
		rd && reg_addr == $past(reg_addr) && reg_addr[3] && !ref_valid |=> !reg_rdata[6] && !reg_rdata[15])
		else $error("written or unused bit after register write");
	flag_nonres_a: assert property (en_reg && ref_valid && ^mode ##1 rd && reg_addr == 6'h20 |=> reg_rdata[15])
		else $error("non-resident flag missing");
	cover property (ref_abort);
	cover property (bus_valid && en_reg && phys_addr[17:16] != 2'h0);
	cover property (rd && reg_addr == 6'h20);
endmodule // parmu_unit_properties
bind parmu_unit parmu_unit_properties chk (.sys_clk, .rst_n, .virt_addr, .ref_valid, .use_prev_mode, .cur_mode,
	.prev_mode, .reg_sel, .reg_write, .reg_addr, .reg_wdata, .reg_rdata, .phys_addr, .bus_valid, .ref_abort);
`default_nettype wire

// *** verification/parmu_cpu_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Processor side: presents references, scrambles an idle address.
// ------------------------------------------------------------
module parmu_cpu_model (
	input  wire logic        sys_clk,
	input  wire logic        cmd_valid,
	input  wire logic [15:0] cmd_addr,
	input  wire logic        cmd_write,
	input  wire logic [4:0]  cmd_mode,
	output      logic [15:0] virt_addr,
	output      logic        ref_valid,
	output      logic        ref_write,
	output      logic        use_prev_mode,
	output      logic [1:0]  cur_mode,
	output      logic [1:0]  prev_mode
);
	logic [15:0] idle_reg = 16'h5a5a;
	// The idle address changes every cycle so a stale value never passes.
	always @(posedge sys_clk) idle_reg <= ~idle_reg ^ 16'h0001;
	// Stores and read-modify-writes are both flagged as writes.
	assign ref_write = cmd_valid & cmd_write;
	assign ref_valid = cmd_valid;
	assign virt_addr = cmd_valid ? cmd_addr : idle_reg;
	assign {use_prev_mode, cur_mode, prev_mode} = cmd_mode;
endmodule // parmu_cpu_model
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Self-checking bench for the relocation unit.
// ------------------------------------------------------------
module tb;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cmd_valid = 1'b0;
	logic        cmd_write = 1'b0;
	logic [15:0] cmd_addr = 16'h0000;
	logic [4:0]  cmd_mode = 5'h00;
	logic        reg_sel = 1'b0;
	logic        reg_write = 1'b0;
	logic [5:0]  reg_addr = 6'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] virt_addr, reg_rdata;
	logic [17:0] phys_addr;
	logic [1:0]  cur_mode, prev_mode;
	logic        ref_valid, ref_write, use_prev_mode, bus_valid, ref_abort;
	logic        en_sh = 1'b0;
	logic [15:0] base_sh [16] = '{default: 16'h0000};
	logic [15:0] desc_sh [16] = '{default: 16'h0000};
	logic [14:0] lens [8] = '{15'h14a9, 15'h14aa, 15'h0000, 15'h0001, 15'h6ad4, 15'h6ad5, 15'h6aff, 15'h7ffe};
	logic [36:0] flags [3] = '{{16'h0000, 16'h8001, 5'h04}, {16'hbf80, 16'h4001, 5'h13}, {16'h2000, 16'h2001, 5'h00}};
	logic [31:0] seed = 32'd82;
	int          bad_count = 0;
	int          samples_checked = 0;
	parmu_unit dut (.sys_clk, .rst_n, .virt_addr, .ref_valid, .ref_write, .use_prev_mode, .cur_mode, .prev_mode,
		.reg_sel, .reg_write, .reg_addr, .reg_wdata, .reg_rdata, .phys_addr, .bus_valid, .ref_abort);
	parmu_cpu_model cpu (.sys_clk, .cmd_valid, .cmd_addr, .cmd_write, .cmd_mode, .virt_addr, .ref_valid,
		.ref_write, .use_prev_mode, .cur_mode, .prev_mode);
	// Clock of 25 ns period.
	initial forever #12.5 sys_clk = ~sys_clk;
	// Xorshift source of repeatable stimulus.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Expected abort flag and physical address of one reference.
	function automatic logic [18:0] exp_ref(input logic [15:0] va, input logic wr, input logic [4:0] md);
		logic [1:0]  m;
		logic [15:0] d;
		logic [6:0]  b;
		logic        bk;
		m = md[4] ? md[1:0] : md[3:2];
		// Only mode 11 reaches the user bank; the illegal codes look into the kernel bank.
		bk = (m == parmu_pkg::MODE_USER);
		d = desc_sh[{bk, va[15:13]}];
		b = va[12:6];
		if (!en_sh)
			return {1'b0, 2'h0, va};
		return {^m | !d[1] | (!d[2] & wr) | (d[3] ? b < d[14:8] : b > d[14:8]),
			base_sh[{bk, va[15:13]}][11:0] + {5'h0, b}, va[5:0]};
	endfunction
	// Compares one value and counts it.
	task automatic check(input logic [18:0] got, input logic [18:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Presents one reference and checks the answer at mid cycle.
	task automatic ref_do(input logic [15:0] va, input logic wr, input logic [4:0] md);
		logic [18:0] e;
		e = exp_ref(va, wr, md);
		reg_sel = 1'b0;
		cmd_valid = 1'b1;
		cmd_addr = va;
		cmd_write = wr;
		cmd_mode = md;
		@(negedge sys_clk);
		check({ref_abort, phys_addr}, e);
		if (en_sh && wr && !e[18])
			desc_sh[{md[4] ? md[0] : md[2], va[15:13]}][6] = 1'b1;
		@(posedge sys_clk);
		#1;
	endtask
	// One register port access; a read is compared the cycle after.
	task automatic reg_do(input logic wr, input logic [5:0] a, input logic [15:0] wd, input logic [15:0] exp);
		cmd_valid = 1'b0;
		reg_sel = 1'b1;
		reg_write = wr;
		reg_addr = a;
		reg_wdata = wd;
		@(posedge sys_clk);
		#1;
		if (!wr)
			check({3'h0, reg_rdata}, {3'h0, exp});
	endtask
	// Writes a page register and updates the expected copy.
	task automatic page_wr(input logic [5:0] a, input logic [15:0] wd);
		reg_do(1'b1, a, wd, 16'h0000);
		if (a[3])
			desc_sh[{a[4], a[2:0]}] = wd & parmu_pkg::DESC_WRITE_MASK;
		else
			base_sh[{a[4], a[2:0]}] = wd & 16'h0fff;
		desc_sh[{a[4], a[2:0]}][6] = 1'b0;
	endtask
	// Reads back one page register against the expected copy.
	task automatic rd_page(input logic [5:0] a);
		reg_do(1'b0, a, 16'h0000, a[3] ? desc_sh[{a[4], a[2:0]}] : base_sh[{a[4], a[2:0]}]);
	endtask
	// Prints the verdict and ends the run.
	task automatic stop_test();
		if (bad_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Cuts a hang short.
	initial begin
		#1000000;
		bad_count++;
		stop_test();
	end
	// Main sequence: reset, pass-through, programming, corners, random traffic.
	initial begin
		logic [15:0] v;
		repeat (16) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		for (int a = 0; a < 64; a++)
			reg_do(1'b0, a[5:0], 16'h0000, 16'h0000);
		repeat (40)
			ref_do(16'(rnd()), 1'b0, 5'(rnd()));
		for (int a = 0; a < 32; a++)
			page_wr(a[5:0], 16'(rnd()) | 16'h0040);
		for (int a = 0; a < 32; a++)
			rd_page(a[5:0]);
		reg_do(1'b1, 6'h20, 16'h0001, 16'h0000);
		en_sh = 1'b1;
		for (int k = 0; k < 8; k++) begin
			page_wr(6'h08, {8'h7f, 5'h00, k[1:0], 1'b0});
			ref_do({3'h0, 13'(rnd())}, k[2], 5'h00);
		end
		rd_page(6'h08);
		page_wr(6'h00, 16'h0000);
		rd_page(6'h08);
		foreach (lens[j]) begin
			page_wr(6'h1d, {1'b0, lens[j][13:7], 4'h0, lens[j][14], 2'h3, 1'b0});
			ref_do({3'h5, lens[j][6:0], 6'h2a}, 1'b1, 5'h13);
		end
		page_wr(6'h09, 16'h7f02);
		rd_page(6'h09);
		foreach (flags[j]) begin
			reg_do(1'b1, 6'h20, 16'h0001, 16'h0000);
			ref_do(flags[j][36:21], 1'b1, flags[j][4:0]);
			reg_do(1'b0, 6'h20, 16'h0000, flags[j][20:5]);
		end
		repeat (600) begin
			v = 16'(rnd());
			if (v[0])
				page_wr({1'b0, v[5:1]}, 16'(rnd()));
			else
				ref_do(16'(rnd()), v[1], v[6:2]);
		end
		for (int a = 0; a < 32; a++)
			rd_page(a[5:0]);
		stop_test();
	end
endmodule // tb
`default_nettype wire
